/* pxc_ext_ctrl2.sv */
// extended control register two with its management frame slave and side effects
`timescale 1ns/1ps
module pxc_ext_ctrl2 (
    // reference clock and system reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // management interface
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_n,
    input  wire logic [4:0] phy_addr,
    // straps
    input  wire logic       node_repeater_strap,
    input  wire logic       sw_priority_strap,
    // link status
    input  wire logic       link_up,
    input  wire logic       link_speed_100,
    input  wire logic       link_full_duplex,
    input  wire logic       remote_fault_in,
    input  wire logic       isolate,
    input  wire logic       sqe_test_inhibit,
    // media activity
    input  wire logic       tx_en,
    input  wire logic       tx_activity,
    input  wire logic       rx_activity,
    input  wire logic       line_collision,
    // transmit drivers
    input  wire logic       line_tx_pos_data,
    input  wire logic       line_tx_neg_data,
    output logic            line_tx_pos,
    output logic            line_tx_pos_oe_n,
    output logic            line_tx_neg,
    output logic            line_tx_neg_oe_n,
    // status and control outputs
    output logic            carrier_sense,
    output logic            collision,
    output logic            speed_100_ind,
    output logic            tx100_power_down,
    output logic            config_from_regs
);

    // strap capture, taken on the first edge after reset release
    logic strap_done_reg, strap_done_next;
    logic repeater_reg, repeater_next;
    logic sw_prio_reg, sw_prio_next;

    always_comb begin
        strap_done_next = 1'b1;
        repeater_next   = repeater_reg;
        sw_prio_next    = sw_prio_reg;
        if (!strap_done_reg) begin
            repeater_next = node_repeater_strap;
            sw_prio_next  = sw_priority_strap;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            repeater_reg   <= 1'b0;
            sw_prio_reg    <= 1'b0;
        end else begin
            strap_done_reg <= strap_done_next;
            repeater_reg   <= repeater_next;
            sw_prio_reg    <= sw_prio_next;
        end
    end

    // management frame slave
    pxc_pkg::pxc_mdio_state_e state_reg, state_next;
    logic        mdc_reg, mdc_prev_reg;
    logic [5:0]  cnt_reg, cnt_next;
    logic [11:0] hdr_reg, hdr_next;
    logic [15:0] shift_reg, shift_next;
    logic [15:0] store_reg, store_next;
    logic        drive_reg, drive_next;
    logic        out_reg, out_next;
    logic        mdc_rise;
    logic        hit;
    logic        is_read;
    logic        is_write;
    logic [15:0] read_value;
    logic [15:0] write_word;

    assign mdc_rise = mdc_reg && !mdc_prev_reg;
    assign hit      = (hdr_reg[9:5] == phy_addr) && (hdr_reg[4:0] == pxc_pkg::PXC_REG_INDEX);
    assign is_read  = hit && (hdr_reg[11:10] == pxc_pkg::PXC_OP_READ);
    assign is_write = hit && (hdr_reg[11:10] == pxc_pkg::PXC_OP_WRITE);

    // reserved bits read back whatever was last written; bit 10 is never stored
    always_comb begin
        read_value = store_reg & pxc_pkg::PXC_STORE_MASK;
        read_value[pxc_pkg::PXC_BIT_REPEATER] = repeater_reg;
        read_value[pxc_pkg::PXC_BIT_SW_PRIO]  = sw_prio_reg;
        read_value[pxc_pkg::PXC_BIT_RFAULT]   = remote_fault_in;
    end

    // reserved write data is stored as given; the manager is relied on to send defaults
    assign write_word = {shift_reg[14:0], mdio_in};

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        hdr_next   = hdr_reg;
        shift_next = shift_reg;
        store_next = store_reg;
        drive_next = drive_reg;
        out_next   = out_reg;
        if (mdc_rise) begin
            case (state_reg)
                pxc_pkg::PXC_ST_PRE: begin
                    if (mdio_in) begin
                        if (cnt_reg < 6'(pxc_pkg::PXC_PREAMBLE_LEN)) begin
                            cnt_next = cnt_reg + 6'h01;
                        end
                    end else if (cnt_reg >= 6'(pxc_pkg::PXC_PREAMBLE_LEN)) begin
                        state_next = pxc_pkg::PXC_ST_START;
                    end else begin
                        cnt_next = 6'h00;
                    end
                end
                pxc_pkg::PXC_ST_START: begin
                    cnt_next   = 6'h00;
                    state_next = mdio_in ? pxc_pkg::PXC_ST_HDR : pxc_pkg::PXC_ST_PRE;
                end
                pxc_pkg::PXC_ST_HDR: begin
                    hdr_next = {hdr_reg[10:0], mdio_in};
                    if (cnt_reg == 6'(pxc_pkg::PXC_HDR_LEN - 1)) begin
                        cnt_next   = 6'h00;
                        state_next = pxc_pkg::PXC_ST_TA;
                    end else begin
                        cnt_next = cnt_reg + 6'h01;
                    end
                end
                pxc_pkg::PXC_ST_TA: begin
                    if (cnt_reg == 6'h00) begin
                        // second turnaround bit is driven low on a read hit
                        shift_next = read_value;
                        drive_next = is_read;
                        out_next   = 1'b0;
                        cnt_next   = 6'h01;
                    end else begin
                        out_next   = shift_reg[15];
                        cnt_next   = 6'h00;
                        state_next = pxc_pkg::PXC_ST_DATA;
                    end
                end
                pxc_pkg::PXC_ST_DATA: begin
                    shift_next = {shift_reg[14:0], mdio_in};
                    out_next   = shift_reg[14];
                    if (cnt_reg == 6'(pxc_pkg::PXC_DATA_LEN - 1)) begin
                        if (is_write) begin
                            store_next = (store_reg & ~pxc_pkg::PXC_WRITE_MASK)
                                       | (write_word & pxc_pkg::PXC_WRITE_MASK);
                        end
                        drive_next = 1'b0;
                        out_next   = 1'b0;
                        cnt_next   = 6'h00;
                        state_next = pxc_pkg::PXC_ST_PRE;
                    end else begin
                        cnt_next = cnt_reg + 6'h01;
                    end
                end
                default: begin
                    drive_next = 1'b0;
                    cnt_next   = 6'h00;
                    state_next = pxc_pkg::PXC_ST_PRE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= pxc_pkg::PXC_ST_PRE;
            mdc_reg      <= 1'b0;
            mdc_prev_reg <= 1'b0;
            cnt_reg      <= 6'h00;
            hdr_reg      <= 12'h000;
            shift_reg    <= 16'h0000;
            store_reg    <= pxc_pkg::PXC_STORE_RESET;
            drive_reg    <= 1'b0;
            out_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            mdc_reg      <= mdc;
            mdc_prev_reg <= mdc_reg;
            cnt_reg      <= cnt_next;
            hdr_reg      <= hdr_next;
            shift_reg    <= shift_next;
            store_reg    <= store_next;
            drive_reg    <= drive_next;
            out_reg      <= out_next;
        end
    end

    assign mdio_out  = out_reg;
    assign mdio_oe_n = !drive_reg;

    // side effects of the register contents
    logic sqe_enable;
    logic sqe_pulse;
    logic crs_reg, crs_next;
    logic col_reg, col_next;
    logic spd_reg, spd_next;
    logic pd_reg, pd_next;

    // test defaults on in node mode; repeater or full duplex always suppress it
    assign sqe_enable = !repeater_reg && !link_full_duplex && !sqe_test_inhibit;

    pxc_sqe_pulse u_sqe (
        .clk         (clk),
        .rst_n       (rst_n),
        .tx_en       (tx_en),
        .test_enable (sqe_enable),
        .sqe_pulse   (sqe_pulse)
    );

    always_comb begin
        crs_next = rx_activity || (!repeater_reg && tx_activity);
        col_next = line_collision || sqe_pulse;
        spd_next = link_up && link_speed_100;
        pd_next  = isolate
                 || (store_reg[pxc_pkg::PXC_BIT_AUTO_PD] && link_up && !link_speed_100);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crs_reg <= 1'b0;
            col_reg <= 1'b0;
            spd_reg <= 1'b0;
            pd_reg  <= 1'b0;
        end else begin
            crs_reg <= crs_next;
            col_reg <= col_next;
            spd_reg <= spd_next;
            pd_reg  <= pd_next;
        end
    end

    assign carrier_sense    = crs_reg;
    assign collision        = col_reg;
    assign speed_100_ind    = spd_reg;
    assign tx100_power_down = pd_reg;
    assign config_from_regs = sw_prio_reg;

    // float both transmit lines while the float bit is set
    assign line_tx_pos      = line_tx_pos_data;
    assign line_tx_neg      = line_tx_neg_data;
    assign line_tx_pos_oe_n = store_reg[pxc_pkg::PXC_BIT_TP_FLOAT];
    assign line_tx_neg_oe_n = store_reg[pxc_pkg::PXC_BIT_TP_FLOAT];

endmodule : pxc_ext_ctrl2

/* pxc_pkg.sv */
// constants and types for the second extended control and status register
package pxc_pkg;

    // register location and layout
    localparam logic [4:0]  PXC_REG_INDEX     = 5'h13;
    localparam int          PXC_BIT_REPEATER  = 15;
    localparam int          PXC_BIT_SW_PRIO   = 14;
    localparam int          PXC_BIT_RFAULT    = 13;
    localparam int          PXC_BIT_TP_FLOAT  = 7;
    localparam int          PXC_BIT_AUTO_PD   = 0;
    localparam logic [15:0] PXC_WRITE_MASK    = 16'h1BFF;
    localparam logic [15:0] PXC_STORE_RESET   = 16'h0001;
    localparam logic [15:0] PXC_STORE_MASK    = 16'h1BFF;

    // management frame fields
    localparam int          PXC_PREAMBLE_LEN  = 32;
    localparam int          PXC_HDR_LEN       = 12;
    localparam int          PXC_TA_LEN        = 2;
    localparam int          PXC_DATA_LEN      = 16;
    localparam logic [1:0]  PXC_OP_READ       = 2'h2;
    localparam logic [1:0]  PXC_OP_WRITE      = 2'h1;

    // timing
    localparam int          PXC_CLK_MHZ       = 25;
    localparam int          PXC_SQE_DELAY_NS  = 800;
    localparam int          PXC_SQE_WIDTH_NS  = 1000;
    localparam int          PXC_SQE_DELAY_CYC = (PXC_SQE_DELAY_NS * PXC_CLK_MHZ + 999) / 1000;
    localparam int          PXC_SQE_WIDTH_CYC = (PXC_SQE_WIDTH_NS * PXC_CLK_MHZ + 999) / 1000;

    typedef enum logic [4:0] {
        PXC_ST_PRE   = 5'h01,
        PXC_ST_START = 5'h02,
        PXC_ST_HDR   = 5'h04,
        PXC_ST_TA    = 5'h08,
        PXC_ST_DATA  = 5'h10
    } pxc_mdio_state_e;

    typedef enum logic [2:0] {
        PXC_SQ_IDLE  = 3'h1,
        PXC_SQ_WAIT  = 3'h2,
        PXC_SQ_PULSE = 3'h4
    } pxc_sqe_state_e;

endpackage : pxc_pkg

/* pxc_sqe_pulse.sv */
// collision test pulse after each transmitted packet
`timescale 1ns/1ps
module pxc_sqe_pulse #(
    parameter int DELAY_CYC = pxc_pkg::PXC_SQE_DELAY_CYC,
    parameter int WIDTH_CYC = pxc_pkg::PXC_SQE_WIDTH_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic tx_en,
    input  wire logic test_enable,
    // result
    output logic      sqe_pulse
);

    pxc_pkg::pxc_sqe_state_e state_reg, state_next;
    logic [7:0]              cnt_reg, cnt_next;
    logic                    tx_en_reg;
    logic                    pulse_reg, pulse_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        pulse_next = 1'b0;
        case (state_reg)
            pxc_pkg::PXC_SQ_IDLE: begin
                if (tx_en_reg && !tx_en && test_enable) begin
                    state_next = pxc_pkg::PXC_SQ_WAIT;
                    cnt_next   = 8'h01;
                end
            end
            pxc_pkg::PXC_SQ_WAIT: begin
                // a new packet or a late inhibit cancels the pending pulse
                if (tx_en || !test_enable) begin
                    state_next = pxc_pkg::PXC_SQ_IDLE;
                end else if (cnt_reg >= 8'(DELAY_CYC)) begin
                    state_next = pxc_pkg::PXC_SQ_PULSE;
                    cnt_next   = 8'h01;
                    pulse_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            pxc_pkg::PXC_SQ_PULSE: begin
                if (cnt_reg >= 8'(WIDTH_CYC)) begin
                    state_next = pxc_pkg::PXC_SQ_IDLE;
                end else begin
                    cnt_next   = cnt_reg + 8'h01;
                    pulse_next = 1'b1;
                end
            end
            default: begin
                state_next = pxc_pkg::PXC_SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pxc_pkg::PXC_SQ_IDLE;
            cnt_reg   <= 8'h00;
            tx_en_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            tx_en_reg <= tx_en;
            pulse_reg <= pulse_next;
        end
    end

    assign sqe_pulse = pulse_reg;

endmodule : pxc_sqe_pulse

/* pxc_ext_ctrl2_monitor.sv */
// concurrent checks on the ports of extended control register two
`timescale 1ns/1ps
module pxc_ext_ctrl2_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management wire
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    // status inputs
    input wire logic link_up,
    input wire logic link_speed_100,
    input wire logic isolate,
    input wire logic tx_en,
    input wire logic rx_activity,
    input wire logic line_collision,
    // outputs
    input wire logic line_tx_pos_oe_n,
    input wire logic line_tx_neg_oe_n,
    input wire logic carrier_sense,
    input wire logic collision,
    input wire logic speed_100_ind,
    input wire logic tx100_power_down
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence tx_end;
        $fell(tx_en) ##0 $past(rst_n);
    endsequence
    // no mdc edge can still be in the sampling pipeline
    sequence mdc_quiet;
        ($stable(mdc))[*5];
    endsequence
    chk_float_pair: assert property (line_tx_pos_oe_n == line_tx_neg_oe_n)
        else $error("transmit float enables differ");
    chk_speed_ind: assert property ($past(rst_n) |-> speed_100_ind == $past(link_up && link_speed_100))
        else $error("speed indication wrong");
    chk_pd_isolate: assert property ($past(rst_n) && $past(isolate) |-> tx100_power_down)
        else $error("isolate did not power down");
    chk_pd_none: assert property ($past(rst_n) && $past(!isolate && (!link_up || link_speed_100)) |-> !tx100_power_down)
        else $error("power down without cause");
    chk_crs_rx: assert property ($past(rst_n) && $past(rx_activity) |-> carrier_sense)
        else $error("carrier sense missed receive");
    chk_sqe_wait: assert property (tx_end |=> (!collision || $past(line_collision))[*8])
        else $error("collision test pulse too early");
    chk_mdio_turn: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("turnaround not driven low");
    chk_mdio_hold: assert property (mdc_quiet ##0 (!mdio_oe_n && $past(!mdio_oe_n)) |-> $stable(mdio_out))
        else $error("read bit changed without mdc edge");
endmodule : pxc_ext_ctrl2_monitor

bind pxc_ext_ctrl2 pxc_ext_ctrl2_monitor u_mon (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .link_up(link_up), .link_speed_100(link_speed_100), .isolate(isolate), .tx_en(tx_en),
    .rx_activity(rx_activity), .line_collision(line_collision), .line_tx_pos_oe_n(line_tx_pos_oe_n),
    .line_tx_neg_oe_n(line_tx_neg_oe_n), .carrier_sense(carrier_sense), .collision(collision),
    .speed_100_ind(speed_100_ind), .tx100_power_down(tx100_power_down));

/* pxc_sta_model.sv */
// management station model driving mdc and the pulled-up data wire
`timescale 1ns/1ps
module pxc_sta_model (
    // clock
    input  wire logic   clk,
    // management wire
    input  wire logic   mdio_out,
    input  wire logic   mdio_oe_n,
    output logic        mdc,
    output logic        mdio_in,
    // read results
    output logic        rd_done,
    output logic [15:0] rd_data
);
    logic drv_en;
    logic drv_bit;
    // released wire floats up to the pull-up level
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
        rd_done = 1'b0;
        rd_data = 16'h0000;
    end
    // one mdc period, half period of 4 clocks; sample just before the rise
    task automatic tick(input logic en, input logic b, output logic s);
        drv_en = en;
        drv_bit = b;
        repeat (4) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (4) @(negedge clk);
        mdc = 1'b0;
    endtask : tick
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] idx, input logic [15:0] wd);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, phy, idx};
        repeat (32) tick(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) tick(1'b1, hdr[i], s);
        if (op == pxc_pkg::PXC_OP_WRITE) begin
            tick(1'b1, 1'b1, s);
            tick(1'b1, 1'b0, s);
            for (int i = 15; i >= 0; i--) tick(1'b1, wd[i], s);
            drv_en = 1'b0;
        end else begin
            repeat (2) tick(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) begin
                tick(1'b0, 1'b1, s);
                rd_data[i] = s;
            end
            rd_done = 1'b1;
            @(negedge clk);
            rd_done = 1'b0;
        end
        repeat (4) @(negedge clk);
    endtask : frame
endmodule : pxc_sta_model

/* tb.sv */
// self-checking bench for extended control register two
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, node_repeater_strap, sw_priority_strap, link_up, link_speed_100, link_full_duplex;
    logic remote_fault_in, isolate, sqe_test_inhibit, tx_en, tx_activity, rx_activity, line_collision;
    logic line_tx_pos_data, line_tx_neg_data, mdc, mdio_in, mdio_out, mdio_oe_n, line_tx_pos, line_tx_neg;
    logic line_tx_pos_oe_n, line_tx_neg_oe_n, carrier_sense, collision, speed_100_ind, tx100_power_down;
    logic config_from_regs, rd_done, b7, b0, rf;
    logic [15:0] rd_data;
    logic [15:0] exp_q[$];
    logic [7:0]  r;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    localparam logic [4:0] PHY = 5'h05;

    pxc_ext_ctrl2 dut (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .phy_addr(PHY), .node_repeater_strap(node_repeater_strap),
        .sw_priority_strap(sw_priority_strap), .link_up(link_up), .link_speed_100(link_speed_100),
        .link_full_duplex(link_full_duplex), .remote_fault_in(remote_fault_in), .isolate(isolate),
        .sqe_test_inhibit(sqe_test_inhibit), .tx_en(tx_en), .tx_activity(tx_activity),
        .rx_activity(rx_activity), .line_collision(line_collision), .line_tx_pos_data(line_tx_pos_data),
        .line_tx_neg_data(line_tx_neg_data), .line_tx_pos(line_tx_pos), .line_tx_pos_oe_n(line_tx_pos_oe_n),
        .line_tx_neg(line_tx_neg), .line_tx_neg_oe_n(line_tx_neg_oe_n), .carrier_sense(carrier_sense),
        .collision(collision), .speed_100_ind(speed_100_ind), .tx100_power_down(tx100_power_down),
        .config_from_regs(config_from_regs));
    pxc_sta_model sta (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in),
        .rd_done(rd_done), .rd_data(rd_data));

    always #10 clk = ~clk;

    task automatic check_pin(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask : check_pin
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word
    task automatic print_verdict();
        // a read whose answer never arrived still leaves its note behind
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("ERROR read queue expected 0 seen %0d", exp_q.size());
        end
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // read results are matched against the oldest expectation
    always @(posedge clk) begin
        if (rd_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("ERROR read word expected none seen %h", rd_data);
            end else
                check_word("read word", exp_q.pop_front(), rd_data);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    function automatic logic [15:0] word(input logic rep, input logic sw, input logic f, input logic t, input logic p);
        return {rep, sw, f, 5'h00, t, 6'h00, p};
    endfunction : word
    task automatic do_reset(input logic rep, input logic sw);
        rst_n = 1'b0;
        node_repeater_strap = rep;
        sw_priority_strap = sw;
        repeat (4) @(negedge clk);
        check_pin("reset float", 1'b0, line_tx_pos_oe_n);
        check_pin("reset drive", 1'b1, mdio_oe_n);
        rst_n = 1'b1;
        @(negedge clk);
        // straps move after capture; bits 15 and 14 must keep the captured levels
        node_repeater_strap = ~rep;
        sw_priority_strap = ~sw;
        repeat (2) @(negedge clk);
    endtask : do_reset
    task automatic rd(input logic [4:0] phy, input logic [15:0] exp);
        exp_q.push_back(exp);
        sta.frame(pxc_pkg::PXC_OP_READ, phy, pxc_pkg::PXC_REG_INDEX, 16'h0000);
    endtask : rd
    task automatic sqe_run(input logic [15:0] exp_w);
        int first;
        logic [15:0] cnt;
        first = -1;
        cnt = 16'h0000;
        tx_en = 1'b1;
        repeat (10) @(negedge clk);
        tx_en = 1'b0;
        for (int k = 0; k < 80; k++) begin
            @(negedge clk);
            if (collision === 1'b1) begin
                cnt++;
                if (first < 0) first = k;
            end
        end
        check_word("sqe width", exp_w, cnt);
        if (exp_w != 0) check_pin("sqe delay", 1'b1, first >= pxc_pkg::PXC_SQE_DELAY_CYC - 1 && first <= pxc_pkg::PXC_SQE_DELAY_CYC + 3);
    endtask : sqe_run

    initial begin
        {clk, rst_n, link_up, link_speed_100, link_full_duplex, remote_fault_in, isolate} = 7'h00;
        {sqe_test_inhibit, tx_en, tx_activity, rx_activity, line_collision, line_tx_pos_data} = 6'h00;
        {line_tx_neg_data, node_repeater_strap, sw_priority_strap} = 3'h0;
        void'($urandom(32'h9a7c_2020));
        do_reset(1'b0, 1'b1);
        check_pin("config", 1'b1, config_from_regs);
        check_pin("float", 1'b0, line_tx_pos_oe_n);
        rd(PHY, word(1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            {b7, b0, rf} = 3'($urandom);
            remote_fault_in = rf;
            // reserved positions carry their defaults
            sta.frame(pxc_pkg::PXC_OP_WRITE, PHY, pxc_pkg::PXC_REG_INDEX, {3'h7, 5'h00, b7, 6'h00, b0});
            sta.frame(pxc_pkg::PXC_OP_WRITE, 5'h06, pxc_pkg::PXC_REG_INDEX, {8'h00, ~b7, 6'h00, ~b0});
            sta.frame(pxc_pkg::PXC_OP_WRITE, PHY, 5'h12, {8'h00, ~b7, 6'h00, ~b0});
            rd(PHY, word(1'b0, 1'b1, rf, b7, b0));
            rd(5'h06, 16'hFFFF);
            check_pin("float pos", b7, line_tx_pos_oe_n);
            check_pin("float neg", b7, line_tx_neg_oe_n);
            repeat (16) begin
                r = 8'($urandom);
                {link_up, link_speed_100, isolate, rx_activity, tx_activity, line_collision} = r[5:0];
                {line_tx_pos_data, line_tx_neg_data} = r[7:6];
                repeat (2) @(negedge clk);
                check_pin("tx pos", r[7], line_tx_pos);
                check_pin("tx neg", r[6], line_tx_neg);
                check_pin("speed", r[5] & r[4], speed_100_ind);
                check_pin("power down", r[3] | (b0 & r[5] & ~r[4]), tx100_power_down);
                check_pin("carrier", r[2] | r[1], carrier_sense);
                check_pin("collision", r[0], collision);
            end
        end
        {link_up, link_speed_100, isolate, rx_activity, tx_activity, line_collision} = 6'h00;
        $display("test write_read done");
        sqe_run(16'(pxc_pkg::PXC_SQE_WIDTH_CYC));
        link_full_duplex = 1'b1;
        sqe_run(16'h0000);
        link_full_duplex = 1'b0;
        sqe_test_inhibit = 1'b1;
        sqe_run(16'h0000);
        sqe_test_inhibit = 1'b0;
        $display("test sqe done");
        remote_fault_in = 1'b0;
        do_reset(1'b1, 1'b0);
        check_pin("config rep", 1'b0, config_from_regs);
        rd(PHY, word(1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        tx_activity = 1'b1;
        repeat (2) @(negedge clk);
        check_pin("carrier rep", 1'b0, carrier_sense);
        tx_activity = 1'b0;
        sqe_run(16'h0000);
        $display("test repeater done");
        print_verdict();
    end
endmodule : tb
